/* File: rtl/pcm_pin_sync.sv */
/*
 * Three-stage synchroniser with agreement filter for one pad input.
 * Assumes an asynchronous input and a single system clock.
 */
`timescale 1ns/1ps
module pcm_pin_sync (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pinIn,
	output logic      levelOut
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;
	logic level_d;

	always_comb begin
		level_d = level_q;
		if (s2_q == s3_q) begin
			level_d = s3_q;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q    <= 1'b0;
			s2_q    <= 1'b0;
			s3_q    <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q    <= pinIn;
			s2_q    <= s1_q;
			s3_q    <= s2_q;
			level_q <= level_d;
		end
	end

	assign levelOut = level_q;
endmodule // pcm_pin_sync

/* File: rtl/pcm_pkg.sv */
/*
 * Types for the counter and charge-pump pin mux.
 * Assumes the constants header is on the include path.
 */
package pcm_pkg;
	typedef enum logic [1:0] {
		PCM_PH_MATCH = 2'b00,
		PCM_PH_FAST  = 2'b01,
		PCM_PH_SLOW  = 2'b10,
		PCM_PH_BOTH  = 2'b11
	} pcm_phase_type;

	typedef enum logic [1:0] {
		PCM_UC_IDLE  = 2'b00,
		PCM_UC_RUN   = 2'b01
	} pcm_ucstate_type;
endpackage

/* File: rtl/pcm_regs.svh */
/*
 * Constants for the counter and charge-pump pin mux: register indices, field
 * positions and reset values.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef PCM_REGS_SVH
`define PCM_REGS_SVH

// Register addresses on the plain port
`define PCM_ADDR_CFG1      4'h0
`define PCM_ADDR_CFG2      4'h1
`define PCM_ADDR_UCMODE    4'h2
`define PCM_ADDR_UCCTRL    4'h3
`define PCM_ADDR_PORTRD    4'h4
`define PCM_ADDR_STATUS    4'h5

// First pin-function word: bit set selects general-purpose input
`define PCM_CFG1_HGPI_BIT  0
`define PCM_CFG1_LGPI_BIT  1
`define PCM_CFG1_RESET     4'h0

// Second pin-function word: bit set selects general-purpose input
`define PCM_CFG2_GPI_BIT   0
`define PCM_CFG2_RESET     4'h0

// Counter mode word fields
`define PCM_UCM_PIN_BIT    0
`define PCM_UCM_PER_BIT    1
`define PCM_UCM_RESET      4'h0

// Counter control word
`define PCM_UCC_START_BIT  0

// Port-read bit positions
`define PCM_RD_HIGH_BIT    0
`define PCM_RD_LOW_BIT     1
`define PCM_RD_PUMP_BIT    2

`endif

/* File: rtl/pll_counter_pin_mux.sv */
/*
 * Pin function mux for the second charge-pump pin and the two counter
 * input pins, with the configuration words reached over a plain port.
 * Assumes phase comparator results and backup come from same-clock logic,
 * while pad inputs are asynchronous.
 */
// Notes on behaviour
// - Pump pin is second charge-pump output or plain input, per second config.
// - Pump mode: divided oscillator faster than reference drives pin low.
// - Pump mode: divided oscillator slower than reference drives pin high.
// - Pump mode: frequencies equal leaves pin floating.
// - Pump polarity is opposite to the main pump outputs.
// - Pump pin floats in backup and during power-on reset; reset selects pump mode.
// - Each counter pin is counter input or plain input, per first config.
// - High counter pin as plain input reads at bit 0.
// - Low counter pin as plain input reads at bit 1.
// - Backup disables counter pin inputs and pulls them down.
// - After reset the high counter pin is a counter input.
// - Low counter pin supports frequency and period measurement by mode word.
// - After reset the counter measures frequency on the high pin.
`timescale 1ns/1ps
`include "pcm_regs.svh"
module pll_counter_pin_mux
	import pcm_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic [3:0] addr,
	input  wire logic [3:0] wrData,
	input  wire logic       wrStrobe,
	input  wire logic       rdStrobe,
	output logic      [3:0] rdData,
	input  wire logic       backup,
	input  wire logic       oscFaster,
	input  wire logic       oscSlower,
	input  wire logic       secondPumpIn,
	output logic            secondPumpOut,
	output logic            secondPumpOe_n,
	input  wire logic       highFreqCountIn,
	input  wire logic       lowFreqCountIn,
	output logic            highPullDown,
	output logic            lowPullDown,
	output logic            counterSignal,
	output logic            counterPeriodMode,
	output logic            counterStart
);
	////////////////////////////////////////////////////////////////////////
	// Configuration words
	logic [3:0]      cfg1_q;
	logic [3:0]      cfg1_d;
	logic [3:0]      cfg2_q;
	logic [3:0]      cfg2_d;
	logic [3:0]      ucMode_q;
	logic [3:0]      ucMode_d;
	logic            start_q;
	logic            start_d;
	pcm_ucstate_type ucState_q;
	pcm_ucstate_type ucState_d;
	logic [3:0]      rdData_q;
	logic [3:0]      rdData_d;

	function automatic logic wrHit(input logic [3:0] a);
		wrHit = wrStrobe && (addr == a);
	endfunction

	// Port-read bit: a pad level shows only while it is a plain input and awake
	function automatic logic portBit(input logic gpi, input logic lvl);
		portBit = gpi && !backup && lvl;
	endfunction

	// Counter feed: a pad reaches the counter only while it is not a plain input
	function automatic logic cntBit(input logic gpi, input logic lvl);
		cntBit = !gpi && lvl;
	endfunction

	always_comb begin
		cfg1_d    = cfg1_q;
		cfg2_d    = cfg2_q;
		ucMode_d  = ucMode_q;
		// Start is a one-cycle pulse
		start_d   = 1'b0;
		ucState_d = ucState_q;
		if (wrHit(`PCM_ADDR_CFG1)) begin
			cfg1_d = wrData;
		end
		if (wrHit(`PCM_ADDR_CFG2)) begin
			cfg2_d = wrData;
		end
		if (wrHit(`PCM_ADDR_UCMODE)) begin
			ucMode_d  = wrData;
			// A new mode stops any measurement in flight
			ucState_d = PCM_UC_IDLE;
		end
		if (wrHit(`PCM_ADDR_UCCTRL)) begin
			start_d = wrData[`PCM_UCC_START_BIT];
			ucState_d = wrData[`PCM_UCC_START_BIT] ? PCM_UC_RUN : PCM_UC_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pad inputs
	logic highLvl;
	logic lowLvl;
	logic pumpLvl;

	// Pads are asynchronous: three flops and an agreement filter each
	pcm_pin_sync uHighSync (
		.clk      (clk),
		.rst      (rst),
		.pinIn    (highFreqCountIn),
		.levelOut (highLvl)
	);

	pcm_pin_sync uLowSync (
		.clk      (clk),
		.rst      (rst),
		.pinIn    (lowFreqCountIn),
		.levelOut (lowLvl)
	);

	pcm_pin_sync uPumpSync (
		.clk      (clk),
		.rst      (rst),
		.pinIn    (secondPumpIn),
		.levelOut (pumpLvl)
	);

	logic highGpi;
	logic lowGpi;
	logic pumpGpi;
	assign highGpi = cfg1_q[`PCM_CFG1_HGPI_BIT];
	assign lowGpi  = cfg1_q[`PCM_CFG1_LGPI_BIT];
	assign pumpGpi = cfg2_q[`PCM_CFG2_GPI_BIT];

	////////////////////////////////////////////////////////////////////////
	// Read path
	always_comb begin
		// Idle cycles read zero, so read data stand for one cycle only
		rdData_d = 4'h0;
		if (rdStrobe) begin
			unique case (addr)
				`PCM_ADDR_CFG1:   rdData_d = cfg1_q;
				`PCM_ADDR_CFG2:   rdData_d = cfg2_q;
				`PCM_ADDR_UCMODE: rdData_d = ucMode_q;
				`PCM_ADDR_STATUS: rdData_d = {3'h0, ucState_q == PCM_UC_RUN};
				`PCM_ADDR_PORTRD: begin
					rdData_d[`PCM_RD_HIGH_BIT] = portBit(highGpi, highLvl);
					rdData_d[`PCM_RD_LOW_BIT]  = portBit(lowGpi, lowLvl);
					rdData_d[`PCM_RD_PUMP_BIT] = portBit(pumpGpi, pumpLvl);
				end
				// Unmapped addresses read zero
				default:          rdData_d = 4'h0;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cfg1_q    <= `PCM_CFG1_RESET;
			cfg2_q    <= `PCM_CFG2_RESET;
			ucMode_q  <= `PCM_UCM_RESET;
			start_q   <= 1'b0;
			ucState_q <= PCM_UC_IDLE;
		end else begin
			cfg1_q    <= cfg1_d;
			cfg2_q    <= cfg2_d;
			ucMode_q  <= ucMode_d;
			start_q   <= start_d;
			ucState_q <= ucState_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdData_q <= 4'h0;
		end else begin
			rdData_q <= rdData_d;
		end
	end

	assign rdData = rdData_q;

	////////////////////////////////////////////////////////////////////////
	// Second charge-pump pin
	pcm_phase_type phase;
	logic          pumpOut_q;
	logic          pumpOut_d;
	logic          pumpOe_n_q;
	logic          pumpOe_n_d;
	// Bit 0 is the faster flag, bit 1 the slower flag
	assign phase = pcm_phase_type'({oscSlower, oscFaster});

	always_comb begin
		pumpOut_d  = 1'b0;
		pumpOe_n_d = 1'b1;
		if (!backup && !pumpGpi) begin
			unique case (phase)
				PCM_PH_FAST: begin
					pumpOut_d  = 1'b0;
					pumpOe_n_d = 1'b0;
				end
				PCM_PH_SLOW: begin
					pumpOut_d  = 1'b1;
					pumpOe_n_d = 1'b0;
				end
				PCM_PH_MATCH: pumpOe_n_d = 1'b1;
				// Both flags at once is taken as a match, so the pin never fights the filter
				PCM_PH_BOTH:  pumpOe_n_d = 1'b1;
			endcase
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pumpOut_q  <= 1'b0;
			pumpOe_n_q <= 1'b1;
		end else begin
			pumpOut_q  <= pumpOut_d;
			pumpOe_n_q <= pumpOe_n_d;
		end
	end

	assign secondPumpOut  = pumpOut_q;
	assign secondPumpOe_n = pumpOe_n_q;

	////////////////////////////////////////////////////////////////////////
	// Counter pins
	logic cntSig_q;
	logic cntSig_d;
	logic pullH_d;
	logic pullL_d;
	logic pullH_q;
	logic pullL_q;

	always_comb begin
		// Pull-downs keep the pads quiet while their inputs are off
		// backup pulls down, input off
		pullH_d  = backup;
		pullL_d  = backup;
		cntSig_d = 1'b0;
		if (!backup) begin
			// Mode bit 0 picks the low pin, else the high pin
			if (ucMode_q[`PCM_UCM_PIN_BIT]) begin
				cntSig_d = cntBit(lowGpi, lowLvl);
			end else begin
				cntSig_d = cntBit(highGpi, highLvl);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cntSig_q <= 1'b0;
			pullH_q  <= 1'b0;
			pullL_q  <= 1'b0;
		end else begin
			cntSig_q <= cntSig_d;
			pullH_q  <= pullH_d;
			pullL_q  <= pullL_d;
		end
	end

	assign highPullDown      = pullH_q;
	assign lowPullDown       = pullL_q;
	assign counterSignal     = cntSig_q;
	assign counterStart      = start_q;

	////////////////////////////////////////////////////////////////////////
	// Counter mode outputs
	logic periodMode_q;
	logic periodMode_d;

	always_comb begin
		periodMode_d = ucMode_q[`PCM_UCM_PER_BIT] && ucMode_q[`PCM_UCM_PIN_BIT];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			periodMode_q <= 1'b0;
		end else begin
			periodMode_q <= periodMode_d;
		end
	end

	assign counterPeriodMode = periodMode_q;
endmodule // pll_counter_pin_mux

/* File: tb/pcm_cpu_model.sv */
/* CPU side: configuration writes and port reads on the plain port.
   Assumes one clock shared with the mux. */
`timescale 1ns/1ps
module pcm_cpu_model (
	input  wire logic       clk,
	output logic      [3:0] addr,
	output logic      [3:0] wrData,
	output logic            wrStrobe,
	output logic            rdStrobe,
	input  wire logic [3:0] rdData
);
	initial begin
		addr = 4'h0;
		wrData = 4'h0;
		wrStrobe = 1'h0;
		rdStrobe = 1'h0;
	end
	// Released lines show the inverse of their last value
	task wr(input logic [3:0] a, input logic [3:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'h1;
		@(posedge clk);
		wrStrobe <= 1'h0;
		addr <= ~a;
		wrData <= ~d;
	endtask
	task rd(input logic [3:0] a, output logic [3:0] d);
		@(posedge clk);
		addr <= a;
		rdStrobe <= 1'h1;
		@(posedge clk);
		rdStrobe <= 1'h0;
		addr <= ~a;
		@(posedge clk);
		d = rdData;
	endtask
endmodule // pcm_cpu_model

/* File: tb/pcm_mux_chk.sv */
/* Port checker for the pin mux.
   Assumes it is bound onto the top module. */
`timescale 1ns/1ps
module pcm_mux_chk (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [3:0] addr,
	input wire logic [3:0] wrData,
	input wire logic       wrStrobe,
	input wire logic       backup,
	input wire logic       oscFaster,
	input wire logic       oscSlower,
	input wire logic       secondPumpOut,
	input wire logic       secondPumpOe_n,
	input wire logic       highPullDown,
	input wire logic       lowPullDown,
	input wire logic       counterSignal,
	input wire logic       counterPeriodMode,
	input wire logic       counterStart
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence sStartWr;
		wrStrobe && addr == 4'h3 && wrData[0];
	endsequence
	sequence sPeriodWr;
		wrStrobe && addr == 4'h2 && wrData[1:0] == 2'h3;
	endsequence
	AST_PUMP_LOW:
		assert property (oscFaster && !oscSlower |=> secondPumpOut == 1'h0 || secondPumpOe_n) else $error("pump not low");
	AST_PUMP_HIGH:
		assert property (!secondPumpOe_n |-> secondPumpOut == $past(oscSlower)) else $error("pump level wrong");
	AST_PUMP_MATCH:
		assert property (oscFaster == oscSlower |=> secondPumpOe_n) else $error("pump not floating");
	AST_BACKUP_Z:
		assert property (backup |=> secondPumpOe_n) else $error("pump driven in backup");
	AST_PULL_ON:
		assert property (backup |=> highPullDown && lowPullDown && !counterSignal) else $error("pull-down missing");
	AST_PULL_OFF:
		assert property (!backup |=> !highPullDown && !lowPullDown) else $error("pull-down stuck");
	AST_PERIOD:
		assert property (sPeriodWr |=> ##1 counterPeriodMode) else $error("period mode not set");
	AST_START:
		assert property (sStartWr |=> counterStart ##1 !counterStart) else $error("start pulse wrong");
endmodule // pcm_mux_chk
bind pll_counter_pin_mux pcm_mux_chk pcm_mux_chk_i (.clk, .rst, .addr, .wrData, .wrStrobe, .backup, .oscFaster,
	.oscSlower, .secondPumpOut, .secondPumpOe_n, .highPullDown, .lowPullDown, .counterSignal, .counterPeriodMode,
	.counterStart);

/* File: tb/pll_counter_pin_mux_tb.sv */
/* Self-checking bench for the pin mux.
   Assumes the CPU model and the bound checker. */
`timescale 1ns/1ps
module pll_counter_pin_mux_tb;
	typedef struct {logic [3:0] cfg; logic f; logic s; logic oeN; logic out;} pcm_row_type;
	logic clk = 1'h0, rst = 1'h1, backup = 1'h0, oscFaster = 1'h0, oscSlower = 1'h0;
	logic highIn = 1'h0, lowIn = 1'h0, padDrive = 1'h0, wrStrobe, rdStrobe;
	logic [3:0] addr, wrData, rdData, d;
	logic pOut, pOeN, hPd, lPd, cSig, cPer, cStart;
	wire pumpPad = pOeN ? padDrive : pOut;
	int n_fail = 0, n_checks = 0;
	pcm_row_type rows [5] = '{'{4'h0, 1'h1, 1'h0, 1'h0, 1'h0}, '{4'h0, 1'h0, 1'h1, 1'h0, 1'h1},
		'{4'h0, 1'h0, 1'h0, 1'h1, 1'h0}, '{4'h0, 1'h1, 1'h1, 1'h1, 1'h0}, '{4'h1, 1'h0, 1'h1, 1'h1, 1'h0}};
	always #12.5 clk = ~clk;
	pcm_cpu_model cpu_i (.clk, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData);
	pll_counter_pin_mux pll_counter_pin_mux_i (.clk, .rst, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .backup,
		.oscFaster, .oscSlower, .secondPumpIn(pumpPad), .secondPumpOut(pOut), .secondPumpOe_n(pOeN),
		.highFreqCountIn(highIn), .lowFreqCountIn(lowIn), .highPullDown(hPd), .lowPullDown(lPd),
		.counterSignal(cSig), .counterPeriodMode(cPer), .counterStart(cStart));
	task chk(input string nm, input logic [3:0] e, input logic [3:0] g);
		n_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#200us n_fail++;
		complete_run;
	end
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		highIn <= 1'h1;
		repeat (6) @(posedge clk);
		#1 chk("pumpOe", 4'h1, {3'h0, pOeN});
		chk("cSig", 4'h1, {3'h0, cSig});
		chk("cPer", 4'h0, {3'h0, cPer});
		$display("reset test done");
		foreach (rows[i]) begin
			cpu_i.wr(4'h1, rows[i].cfg);
			oscFaster <= rows[i].f;
			oscSlower <= rows[i].s;
			repeat (2) @(posedge clk);
			#1 chk("pumpOe", {3'h0, rows[i].oeN}, {3'h0, pOeN});
			if (!rows[i].oeN) chk("pumpOut", {3'h0, rows[i].out}, {3'h0, pOut});
		end
		$display("pump table done");
		cpu_i.wr(4'h0, 4'h3);
		lowIn <= 1'h0;
		padDrive <= 1'h1;
		repeat (6) @(posedge clk);
		cpu_i.rd(4'h4, d);
		chk("portRd", 4'h5, d);
		chk("cSig", 4'h0, {3'h0, cSig});
		highIn <= 1'h0;
		lowIn <= 1'h1;
		padDrive <= 1'h0;
		repeat (6) @(posedge clk);
		cpu_i.rd(4'h4, d);
		chk("portRd", 4'h2, d);
		$display("port read done");
		cpu_i.wr(4'h1, 4'h0);
		backup <= 1'h1;
		highIn <= 1'h1;
		repeat (6) @(posedge clk);
		#1 chk("pulls", 4'h3, {2'h0, hPd, lPd});
		chk("pumpOe", 4'h1, {3'h0, pOeN});
		cpu_i.rd(4'h4, d);
		chk("portRd", 4'h0, d);
		backup <= 1'h0;
		$display("backup test done");
		cpu_i.wr(4'h0, 4'h0);
		cpu_i.wr(4'h2, 4'h3);
		highIn <= 1'h0;
		repeat (6) @(posedge clk);
		#1 chk("cPer", 4'h1, {3'h0, cPer});
		chk("cSig", 4'h1, {3'h0, cSig});
		cpu_i.wr(4'h3, 4'h1);
		#1 chk("cStart", 4'h1, {3'h0, cStart});
		cpu_i.rd(4'h5, d);
		chk("status", 4'h1, d);
		cpu_i.wr(4'h2, 4'h3);
		cpu_i.rd(4'h5, d);
		chk("status", 4'h0, d);
		cpu_i.wr(4'h2, 4'h2);
		repeat (3) @(posedge clk);
		#1 chk("cPer", 4'h0, {3'h0, cPer});
		chk("cSig", 4'h0, {3'h0, cSig});
		cpu_i.wr(4'h2, 4'h1);
		repeat (3) @(posedge clk);
		#1 chk("cPer", 4'h0, {3'h0, cPer});
		chk("cSig", 4'h1, {3'h0, cSig});
		$display("counter test done");
		complete_run;
	end
endmodule // pll_counter_pin_mux_tb
